// ### hdl/clsb_pkg.sv
package clsb_pkg;
  // Clock and task cycle times
  localparam int CLK_HZ     = 20_000_000;
  localparam int TASK_A_MS  = 2;
  localparam int TASK_B_MS  = 5;
  localparam int TASK_C_MS  = 10;
  localparam int TASK_D_MS  = 20;
  localparam int CYC_TASK_A = CLK_HZ / 1000 * TASK_A_MS;
  localparam int CYC_TASK_B = CLK_HZ / 1000 * TASK_B_MS;
  localparam int CYC_TASK_C = CLK_HZ / 1000 * TASK_C_MS;
  localparam int CYC_TASK_D = CLK_HZ / 1000 * TASK_D_MS;
  localparam int TICK_W     = 19;
  localparam logic [1:0] TSEL_A = 2'h0;
  localparam logic [1:0] TSEL_B = 2'h1;
  localparam logic [1:0] TSEL_C = 2'h2;
  localparam logic [1:0] TSEL_D = 2'h3;

  // Widths
  localparam int SEL_W  = 13;
  localparam int FN_W   = 11;
  localparam int PARM_W = 21;
  localparam int CNT_W  = 16;
  localparam int ELAP_W = 24;
  localparam int NUM_STATUS = 106;
  localparam int NUM_STEP   = 200;
  localparam int NUM_TERM   = 4;

  // Input selection codes
  localparam logic [12:0] IN_NEG_OFS  = 13'h3e8;
  localparam logic [12:0] IN_NEG1_LO  = 13'h3e8;
  localparam logic [12:0] IN_NEG2_LO  = 13'hbb8;
  localparam logic [12:0] IN_NEG3_LO  = 13'h1388;
  localparam logic [12:0] IN_BAND     = 13'h3e8;
  localparam logic [12:0] IN_STAT_MAX = 13'h069;
  localparam logic [12:0] IN_STAT_UDO = 13'h01b;
  localparam logic [12:0] IN_STEP_LO  = 13'h7d1;
  localparam logic [12:0] IN_STEP_HI  = 13'h898;
  localparam logic [12:0] IN_TERM_LO  = 13'hfa1;
  localparam logic [12:0] IN_TERM_HI  = 13'hfa4;

  // Function selection codes
  localparam logic [10:0] FN_INV_OFS = 11'h3e8;
  localparam logic [10:0] FN_INV_END = 11'h7d0;
  localparam logic [10:0] FN_GRP_DIV = 11'h00a;
  localparam logic [10:0] FN_HOLD_LO = 11'h064;
  localparam logic [10:0] FN_HOLD_HI = 11'h069;
  localparam logic [10:0] FN_UP      = 11'h06e;
  localparam logic [10:0] FN_DN      = 11'h078;
  localparam logic [10:0] FN_TMR     = 11'h082;

  // Timer parameter is in hundredths of a second
  localparam int PARM_MS_SCALE = 10;

  typedef enum {FK_OFF, FK_THRU, FK_AND, FK_OR, FK_XOR, FK_SETP, FK_RSTP,
                FK_RISE, FK_FALL, FK_BOTH, FK_HOLD, FK_UP, FK_DN,
                FK_TMR} clsb_kind_t;
endpackage

// ### hdl/clsb_step.sv
`timescale 1ns/10ps
// Operation
// [RL1] Edge detector output pulse lasts exactly one task cycle.
// [RL2] Hold modes pass input while hold control OFF, freeze while ON.
// [RL3] Up counter adds one per rising edge; output ON at target.
// [RL4] Up counter clear input returns count to zero.
// [RL5] Down counter subtracts one per rising edge; output ON at zero.
// [RL6] Down counter clear input reloads the starting value.
// [RL7] Reset timer: rising input sets output, expiry drops it.
// [RL8] Reset timer clear zeroes elapsed time and forces output OFF.
// [RL9] Function code plus 1000 inverts the block output.
// [RL10] Input code plus 1000 delivers the same source inverted.
// [RL11] Codes 2001 to 2200 select step outputs 1 to 200.
// [RL12] Codes 4001 to 4004 select terminal inputs one to four.
// [RL13] Codes 0 to 105 select status outputs, except code 27.
// [RL14] Status codes 111 to 120 are rejected as input selections.
// [RL15] Function code 0 keeps the output permanently OFF.
// [RL16] Counter value is parameter times 100; 0.01 gives one.
// [RL17] Negative timer or counter parameters act as zero.
// [RL18] Set-priority flip-flop: input one wins, else input two clears.
// [RL19] Reset-priority flip-flop: input two wins, else input one sets.
// [RL20] Inputs sampled, outputs updated once per task cycle only.
module clsb_step #(
  parameter logic [18:0] CYC_A = 19'(clsb_pkg::CYC_TASK_A),
  parameter logic [18:0] CYC_B = 19'(clsb_pkg::CYC_TASK_B),
  parameter logic [18:0] CYC_C = 19'(clsb_pkg::CYC_TASK_C),
  parameter logic [18:0] CYC_D = 19'(clsb_pkg::CYC_TASK_D)
) (
  input  wire logic          clk_sys,             // System clock
  input  wire logic          rst_n,               // Sync reset
  input  wire logic [1:0]    task_cycle_sel,      // Task cycle length
  input  wire logic [10:0]   block_select,        // Function code
  input  wire logic [12:0]   first_input_select,  // Input 1 code
  input  wire logic [12:0]   second_input_select, // Input 2 code
  input  wire logic [20:0]   function_value,      // Signed hundredths
  input  wire logic [105:0]  status_outputs,      // Drive status signals
  input  wire logic [199:0]  step_outputs,        // All step outputs
  input  wire logic [3:0]    terminal_inputs,     // Terminal inputs
  output logic               step_out,            // Block output
  output logic               task_tick,           // Task cycle pulse
  output logic [15:0]        count_value          // Counter state
);
  logic [18:0] tick_cnt, next_tick_cnt, period;
  logic        next_task_tick;
  logic        raw, next_raw, prev1, next_prev1, inv, next_inv;
  logic        next_step_out;
  logic [15:0] next_count, target;
  logic [23:0] elapsed, next_elapsed, limit_ms, step_ms;
  logic        s1, s2, rise1;
  clsb_pkg::clsb_kind_t kind;

  // Resolve one input selection code to a signal level
  function automatic logic pick_src(input logic [12:0] code,
                                    input logic [105:0] st,
                                    input logic [199:0] sp,
                                    input logic [3:0]   tm);
    logic [12:0] b;
    logic        neg, v, ok;
    b = code;
    neg = 1'b0;
    v = 1'b0;
    ok = 1'b1;
    if ((code >= clsb_pkg::IN_NEG1_LO &&
         code <  clsb_pkg::IN_NEG1_LO + clsb_pkg::IN_BAND) ||
        (code >= clsb_pkg::IN_NEG2_LO &&
         code <  clsb_pkg::IN_NEG2_LO + clsb_pkg::IN_BAND) ||
        (code >= clsb_pkg::IN_NEG3_LO &&
         code <  clsb_pkg::IN_NEG3_LO + clsb_pkg::IN_BAND)) begin
      b = code - clsb_pkg::IN_NEG_OFS; // RL10
      neg = 1'b1;
    end
    if (b <= clsb_pkg::IN_STAT_MAX && b != clsb_pkg::IN_STAT_UDO) begin
      v = st[b[6:0]]; // RL13
    end else if (b >= clsb_pkg::IN_STEP_LO && b <= clsb_pkg::IN_STEP_HI) begin
      v = sp[8'(b - clsb_pkg::IN_STEP_LO)]; // RL11
    end else if (b >= clsb_pkg::IN_TERM_LO && b <= clsb_pkg::IN_TERM_HI) begin
      v = tm[2'(b - clsb_pkg::IN_TERM_LO)]; // RL12
    end else begin
      ok = 1'b0; // RL14
    end
    return ok & (v ^ neg);
  endfunction

  // Decode the function code, ignoring the inversion offset
  function automatic clsb_pkg::clsb_kind_t fn_kind(input logic [10:0] sel);
    logic [10:0] b, g;
    clsb_pkg::clsb_kind_t k;
    b = (sel >= clsb_pkg::FN_INV_OFS) ? sel - clsb_pkg::FN_INV_OFS : sel;
    g = b / clsb_pkg::FN_GRP_DIV;
    k = clsb_pkg::FK_OFF;
    if (b >= clsb_pkg::FN_HOLD_LO && b <= clsb_pkg::FN_HOLD_HI) begin
      k = clsb_pkg::FK_HOLD;
    end else if (b == clsb_pkg::FN_UP) begin
      k = clsb_pkg::FK_UP;
    end else if (b == clsb_pkg::FN_DN) begin
      k = clsb_pkg::FK_DN;
    end else if (b == clsb_pkg::FN_TMR) begin
      k = clsb_pkg::FK_TMR;
    end else if (b < clsb_pkg::FN_HOLD_LO) begin
      case (g)
        11'h001: k = clsb_pkg::FK_THRU;
        11'h002: k = clsb_pkg::FK_AND;
        11'h003: k = clsb_pkg::FK_OR;
        11'h004: k = clsb_pkg::FK_XOR;
        11'h005: k = clsb_pkg::FK_SETP;
        11'h006: k = clsb_pkg::FK_RSTP;
        11'h007: k = clsb_pkg::FK_RISE;
        11'h008: k = clsb_pkg::FK_FALL;
        11'h009: k = clsb_pkg::FK_BOTH;
        default: k = clsb_pkg::FK_OFF;
      endcase
    end
    return k;
  endfunction

  // Task cycle divider
  always_comb begin
    case (task_cycle_sel)
      clsb_pkg::TSEL_A: period = CYC_A;
      clsb_pkg::TSEL_B: period = CYC_B;
      clsb_pkg::TSEL_C: period = CYC_C;
      default:          period = CYC_D;
    endcase
    case (task_cycle_sel)
      clsb_pkg::TSEL_A: step_ms = 24'(clsb_pkg::TASK_A_MS);
      clsb_pkg::TSEL_B: step_ms = 24'(clsb_pkg::TASK_B_MS);
      clsb_pkg::TSEL_C: step_ms = 24'(clsb_pkg::TASK_C_MS);
      default:          step_ms = 24'(clsb_pkg::TASK_D_MS);
    endcase
    next_task_tick = (tick_cnt >= period - 19'h00001);
    next_tick_cnt = next_task_tick ? 19'h00000 : tick_cnt + 19'h00001;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tick_cnt <= 19'h00000;
      task_tick <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      task_tick <= next_task_tick;
    end
  end

  // Step evaluation, once per task cycle
  always_comb begin
    s1 = pick_src(first_input_select, status_outputs, step_outputs,
                  terminal_inputs);
    s2 = pick_src(second_input_select, status_outputs, step_outputs,
                  terminal_inputs);
    rise1 = s1 & ~prev1;
    kind = fn_kind(block_select);
    target = function_value[20] ? 16'h0000 : function_value[15:0]; // RL16 RL17
    limit_ms = 24'(function_value[19:0] * clsb_pkg::PARM_MS_SCALE);
    if (function_value[20]) begin
      limit_ms = 24'h000000; // RL17
    end
    next_raw = raw;
    next_prev1 = prev1;
    next_inv = inv;
    next_count = count_value;
    next_elapsed = elapsed;
    next_step_out = step_out;
    if (task_tick) begin // RL20
      next_prev1 = s1;
      next_inv = (block_select >= clsb_pkg::FN_INV_OFS);
      case (kind)
        clsb_pkg::FK_THRU: next_raw = s1;
        clsb_pkg::FK_AND:  next_raw = s1 & s2;
        clsb_pkg::FK_OR:   next_raw = s1 | s2;
        clsb_pkg::FK_XOR:  next_raw = s1 ^ s2;
        clsb_pkg::FK_SETP: next_raw = s1 ? 1'b1 : (s2 ? 1'b0 : raw); // RL18
        clsb_pkg::FK_RSTP: next_raw = s2 ? 1'b0 : (s1 ? 1'b1 : raw); // RL19
        clsb_pkg::FK_RISE: next_raw = rise1; // RL1
        clsb_pkg::FK_FALL: next_raw = ~s1 & prev1; // RL1
        clsb_pkg::FK_BOTH: next_raw = s1 ^ prev1; // RL1
        clsb_pkg::FK_HOLD: next_raw = s2 ? raw : s1; // RL2
        clsb_pkg::FK_UP: begin
          if (s2) begin
            next_count = 16'h0000; // RL4
          end else if (rise1 && count_value != 16'hffff) begin
            next_count = count_value + 16'h0001; // RL3
          end
          next_raw = (next_count == target); // RL3
        end
        clsb_pkg::FK_DN: begin
          if (s2) begin
            next_count = target; // RL6
          end else if (rise1 && count_value != 16'h0000) begin
            next_count = count_value - 16'h0001; // RL5
          end
          next_raw = (next_count == 16'h0000); // RL5
        end
        clsb_pkg::FK_TMR: begin
          if (s2) begin
            next_elapsed = 24'h000000; // RL8
            next_raw = 1'b0; // RL8
          end else if (rise1) begin
            next_elapsed = 24'h000000; // RL7
            next_raw = 1'b1; // RL7
          end else if (raw) begin
            next_elapsed = elapsed + step_ms;
            next_raw = (next_elapsed < limit_ms); // RL7
          end
        end
        default: next_raw = 1'b0; // RL15
      endcase
      next_step_out = (kind == clsb_pkg::FK_OFF) ? 1'b0 // RL15
                                                 : next_raw ^ next_inv; // RL9
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      raw <= 1'b0;
      prev1 <= 1'b0;
      inv <= 1'b0;
      count_value <= 16'h0000;
      elapsed <= 24'h000000;
      step_out <= 1'b0;
    end else begin
      raw <= next_raw;
      prev1 <= next_prev1;
      inv <= next_inv;
      count_value <= next_count;
      elapsed <= next_elapsed;
      step_out <= next_step_out;
    end
  end

  // Checks
  property p_out_per_tick; // RL20
    @(posedge clk_sys) disable iff (!rst_n)
      !task_tick |=> $stable(step_out) && $stable(count_value);
  endproperty
  a_out_per_tick: assert property (p_out_per_tick) // RL20
    else $error("output moved outside a task cycle");
  property p_edge_one; // RL1
    @(posedge clk_sys) disable iff (!rst_n)
      task_tick && kind == clsb_pkg::FK_RISE && raw && $stable(block_select)
        && $stable(first_input_select) |=> !raw;
  endproperty
  a_edge_one: assert property (p_edge_one) // RL1
    else $error("edge pulse longer than one task cycle");
  property p_hold; // RL2
    @(posedge clk_sys) disable iff (!rst_n)
      task_tick && kind == clsb_pkg::FK_HOLD && s2 |=> raw == $past(raw);
  endproperty
  a_hold: assert property (p_hold) // RL2
    else $error("hold did not freeze");
  property p_up; // RL3
    @(posedge clk_sys) disable iff (!rst_n)
      task_tick && kind == clsb_pkg::FK_UP && !s2 && rise1 &&
        count_value != 16'hffff |=> count_value == $past(count_value) + 16'h1;
  endproperty
  a_up: assert property (p_up) // RL3
    else $error("up count missed an edge");
  property p_up_clr; // RL4
    @(posedge clk_sys) disable iff (!rst_n)
      task_tick && kind == clsb_pkg::FK_UP && s2 |=> count_value == 16'h0
        ##1 count_value == 16'h0;
  endproperty
  a_up_clr: assert property (p_up_clr) // RL4
    else $error("up count not cleared");
  property p_dn; // RL5
    @(posedge clk_sys) disable iff (!rst_n)
      task_tick && kind == clsb_pkg::FK_DN && !s2 && rise1 &&
        count_value == 16'h1 |=> count_value == 16'h0 && raw;
  endproperty
  a_dn: assert property (p_dn) // RL5
    else $error("down count did not reach zero");
  property p_dn_clr; // RL6
    @(posedge clk_sys) disable iff (!rst_n)
      task_tick && kind == clsb_pkg::FK_DN && s2 |=>
        count_value == $past(target);
  endproperty
  a_dn_clr: assert property (p_dn_clr) // RL6
    else $error("down count not reloaded");
  property p_tmr_clr; // RL8
    @(posedge clk_sys) disable iff (!rst_n)
      task_tick && kind == clsb_pkg::FK_TMR && s2 |=> !raw && elapsed == 24'h0;
  endproperty
  a_tmr_clr: assert property (p_tmr_clr) // RL8
    else $error("timer clear ignored");
  property p_inv; // RL9
    @(posedge clk_sys) disable iff (!rst_n)
      task_tick && kind != clsb_pkg::FK_OFF |=> step_out == (raw ^ inv);
  endproperty
  a_inv: assert property (p_inv) // RL9
    else $error("output inversion wrong");
  property p_off; // RL15
    @(posedge clk_sys) disable iff (!rst_n)
      task_tick && block_select == 11'h000 |=> !step_out;
  endproperty
  a_off: assert property (p_off) // RL15
    else $error("unassigned step output not OFF");
endmodule

// ### test/clsb_far_side.sv
`timescale 1ns/10ps
// Drive status signals, other step outputs and terminal inputs
module clsb_far_side (
  input  wire logic [31:0]  want_stat, // Status codes 0 to 31
  input  wire logic [1:0]   want_step, // Steps 1 and 200
  input  wire logic [3:0]   want_term, // Terminal inputs
  output logic      [105:0] stat_bus,  // Status bus
  output logic      [199:0] step_bus,  // Step output bus
  output logic      [3:0]   term_bus   // Terminal bus
);
  // Codes above 31 stay OFF
  assign stat_bus = {74'h0, want_stat};
  assign step_bus = {want_step[1], 198'h0, want_step[0]};
  assign term_bus = want_term;
endmodule

// ### test/clsb_step_bench.sv
`timescale 1ns/10ps
module clsb_step_bench;
  typedef struct {
    logic [10:0] b;
    logic [12:0] i1;
    logic [12:0] i2;
    logic [31:0] st;
    logic [1:0]  sp;
    logic [3:0]  tm;
    logic        e;
  } clsb_row_t;
  logic          clk_sys = 1'b0;
  logic          rst_n = 1'b0;
  logic [1:0]    tsel = 2'h0;
  logic [10:0]   blk = 11'h000;
  logic [12:0]   s1 = 13'h005;
  logic [12:0]   s2 = 13'h006;
  logic [20:0]   fval = 21'h000000;
  logic [31:0]   want_stat = 32'h0;
  logic [1:0]    want_step = 2'h0;
  logic [3:0]    want_term = 4'h0;
  logic [105:0]  stat_bus;
  logic [199:0]  step_bus;
  logic [3:0]    term_bus;
  logic          step_out;
  logic          task_tick;
  logic [15:0]   count_value;
  int            err_count = 0;
  int            n_compared = 0;
  int            n;
  int            cyc_t[4] = '{8, 20, 40, 80};
  clsb_row_t rows[17] = '{
    '{11'h00a, 13'h005, 13'h000, 32'h20, 2'h0, 4'h0, 1'b1},
    '{11'h00a, 13'h005, 13'h000, 32'h00, 2'h0, 4'h0, 1'b0},
    '{11'h014, 13'h005, 13'h006, 32'h60, 2'h0, 4'h0, 1'b1},
    '{11'h014, 13'h005, 13'h006, 32'h20, 2'h0, 4'h0, 1'b0},
    '{11'h01e, 13'h005, 13'h006, 32'h40, 2'h0, 4'h0, 1'b1},
    '{11'h028, 13'h005, 13'h006, 32'h60, 2'h0, 4'h0, 1'b0},
    '{11'h028, 13'h005, 13'h006, 32'h20, 2'h0, 4'h0, 1'b1},
    '{11'h3f2, 13'h005, 13'h000, 32'h20, 2'h0, 4'h0, 1'b0},
    '{11'h00a, 13'h3ed, 13'h000, 32'h00, 2'h0, 4'h0, 1'b1},
    '{11'h00a, 13'h7d1, 13'h000, 32'h00, 2'h1, 4'h0, 1'b1},
    '{11'h00a, 13'h898, 13'h000, 32'h00, 2'h2, 4'h0, 1'b1},
    '{11'h00a, 13'hfa1, 13'h000, 32'h00, 2'h0, 4'h1, 1'b1},
    '{11'h00a, 13'hfa4, 13'h000, 32'h00, 2'h0, 4'h8, 1'b1},
    '{11'h00a, 13'hfa4, 13'h000, 32'h00, 2'h0, 4'h7, 1'b0},
    '{11'h00a, 13'h01b, 13'h000, 32'h0800_0000, 2'h0, 4'h0, 1'b0},
    '{11'h00a, 13'h06f, 13'h000, 32'hffff_ffff, 2'h3, 4'hf, 1'b0},
    '{11'h000, 13'h005, 13'h000, 32'h20, 2'h0, 4'h0, 1'b0}};
  clsb_far_side u_far (
    .want_stat (want_stat),
    .want_step (want_step),
    .want_term (want_term),
    .stat_bus  (stat_bus),
    .step_bus  (step_bus),
    .term_bus  (term_bus));
  clsb_step #(.CYC_A(19'h8), .CYC_B(19'h14), .CYC_C(19'h28),
              .CYC_D(19'h50)) u_dut (
    .clk_sys             (clk_sys),
    .rst_n               (rst_n),
    .task_cycle_sel      (tsel),
    .block_select        (blk),
    .first_input_select  (s1),
    .second_input_select (s2),
    .function_value      (fval),
    .status_outputs      (stat_bus),
    .step_outputs        (step_bus),
    .terminal_inputs     (term_bus),
    .step_out            (step_out),
    .task_tick           (task_tick),
    .count_value         (count_value));
  always #25 clk_sys = ~clk_sys;
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_zero();
    chk(count_value, 16'h0);
    chk({14'h0, step_out, task_tick}, 16'h0);
  endtask
  // Returns just after the edge that samples the inputs
  task automatic tick();
    int i;
    i = 0;
    @(negedge clk_sys);
    while (task_tick !== 1'b1 && i < 200) begin
      @(negedge clk_sys);
      i++;
    end
    if (i >= 200) begin
      err_count++;
      $display("unexpected at %0t: no task tick", $time);
      report_and_stop();
    end
    @(posedge clk_sys);
    #1;
  endtask
  task automatic mode(input logic [10:0] b, input logic [20:0] v);
    @(posedge clk_sys);
    blk <= b;
    fval <= v;
  endtask
  task automatic sc(input logic a, input logic c, input logic e);
    @(posedge clk_sys);
    want_stat <= {25'h0, c, a, 5'h0};
    tick();
    chk(16'(step_out), 16'(e));
  endtask
  initial begin
    repeat (19) @(posedge clk_sys);
    #1;
    chk_zero();
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) begin
      @(posedge clk_sys);
      #1;
      chk_zero();
    end
    $display("reset test done");
    foreach (rows[k]) begin
      @(posedge clk_sys);
      blk <= rows[k].b;
      s1 <= rows[k].i1;
      s2 <= rows[k].i2;
      want_stat <= rows[k].st;
      want_step <= rows[k].sp;
      want_term <= rows[k].tm;
      tick();
      chk(16'(step_out), 16'(rows[k].e));
    end
    $display("selection table done");
    @(posedge clk_sys);
    s1 <= 13'h005;
    s2 <= 13'h006;
    mode(11'h046, 21'h0);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      tsel <= 2'(k);
      sc(1'b0, 1'b0, 1'b0);
      sc(1'b0, 1'b0, 1'b0);
      sc(1'b1, 1'b0, 1'b1);
      n = 0;
      while (step_out === 1'b1 && n < 300) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      chk(16'(n), 16'(cyc_t[k]));
    end
    @(posedge clk_sys);
    tsel <= 2'h0;
    $display("edge pulse test done");
    mode(11'h050, 21'h0);
    sc(1'b1, 1'b0, 1'b0);
    sc(1'b0, 1'b0, 1'b1);
    sc(1'b0, 1'b0, 1'b0);
    mode(11'h05a, 21'h0);
    sc(1'b1, 1'b0, 1'b1);
    mode(11'h032, 21'h0);
    sc(1'b1, 1'b0, 1'b1);
    sc(1'b0, 1'b0, 1'b1);
    sc(1'b0, 1'b1, 1'b0);
    sc(1'b1, 1'b1, 1'b1);
    mode(11'h03c, 21'h0);
    sc(1'b1, 1'b1, 1'b0);
    sc(1'b1, 1'b0, 1'b1);
    sc(1'b0, 1'b0, 1'b1);
    sc(1'b0, 1'b1, 1'b0);
    mode(11'h064, 21'h0);
    sc(1'b1, 1'b0, 1'b1);
    sc(1'b0, 1'b1, 1'b1);
    sc(1'b0, 1'b0, 1'b0);
    $display("flip-flop and hold test done");
    mode(11'h06e, 21'h3);
    sc(1'b0, 1'b1, 1'b0);
    for (int k = 1; k <= 3; k++) begin
      sc(1'b0, 1'b0, 1'b0);
      sc(1'b1, 1'b0, k == 3);
      chk(count_value, 16'(k));
    end
    sc(1'b0, 1'b1, 1'b0);
    chk(count_value, 16'h0);
    mode(11'h078, 21'h2);
    sc(1'b0, 1'b1, 1'b0);
    chk(count_value, 16'h2);
    sc(1'b1, 1'b0, 1'b0);
    sc(1'b0, 1'b0, 1'b0);
    sc(1'b1, 1'b0, 1'b1);
    chk(count_value, 16'h0);
    mode(11'h078, 21'h1ffffb);
    sc(1'b0, 1'b1, 1'b1);
    chk(count_value, 16'h0);
    $display("counter test done");
    mode(11'h082, 21'h1);
    sc(1'b0, 1'b1, 1'b0);
    sc(1'b1, 1'b0, 1'b1);
    repeat (4) tick();
    chk(16'(step_out), 16'h1);
    tick();
    chk(16'(step_out), 16'h0);
    sc(1'b0, 1'b0, 1'b0);
    sc(1'b1, 1'b0, 1'b1);
    sc(1'b1, 1'b1, 1'b0);
    sc(1'b1, 1'b0, 1'b0);
    $display("timer test done");
    mode(11'h456, 21'h5);
    sc(1'b0, 1'b0, 1'b1);
    sc(1'b1, 1'b0, 1'b1);
    chk(count_value, 16'h1);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_zero();
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) begin
      @(posedge clk_sys);
      #1;
      chk_zero();
    end
    tick();
    chk(16'(step_out), 16'h1);
    $display("second reset test done");
    report_and_stop();
  end
endmodule
